//--- dsw_pkg.sv
// package for the device setup word decoder
`default_nettype none
package dsw_pkg;
  localparam logic [13:0] SETUP_WORD_ADDR = 14'h2007;
  localparam logic [13:0] SPECIAL_SPACE_LO = 14'h2000;
  localparam logic [13:0] SPECIAL_SPACE_HI = 14'h3fff;
  localparam int SETUP_WORD_W = 14;
  localparam logic [13:0] SETUP_WORD_RESET = 14'h31ff;
  localparam logic [13:0] SETUP_IMPL_MASK = 14'h31ff;
  localparam int BG_HI = 13;
  localparam int BG_LO = 12;
  localparam int DATA_PROT_BIT = 8;
  localparam int PROG_PROT_BIT = 7;
  localparam int BROWNOUT_BIT = 6;
  localparam int RESET_PIN_BIT = 5;
  localparam int POWERUP_TIMER_BIT = 4;
  localparam int WATCHDOG_BIT = 3;
  localparam int CLKSEL_HI = 2;
  localparam int CLKSEL_LO = 0;
  localparam int SYS_CLK_MHZ = 125;
  localparam int POWERUP_TIMER_MS = 72;
  localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * 1000 * SYS_CLK_MHZ;
  localparam int OST_CYCLES_DEFAULT = 1024;
  localparam int EE_DEPTH_DEFAULT = 128;
  localparam int PM_DEPTH_DEFAULT = 1024;

  typedef enum logic [2:0] {
    CLK_LOW_POWER_XTAL = 3'b000,
    CLK_STD_XTAL = 3'b001,
    CLK_HIGH_SPEED_XTAL = 3'b010,
    CLK_EXTERNAL = 3'b011,
    CLK_INTERNAL_OSCILLATOR_IO = 3'b100,
    CLK_INTERNAL_OSCILLATOR_CLKOUT = 3'b101,
    CLK_RC_IO = 3'b110,
    CLK_RC_CLKOUT = 3'b111
  } dsw_clksel_t;

  typedef struct packed {
    logic [1:0] bandgapTrim;
    logic dataProtect;
    logic progProtect;
    logic brownoutDetectEn;
    logic resetPinIsReset;
    logic powerupTimerEn;
    logic watchdogEn;
    dsw_clksel_t clockSourceSelect;
  } dsw_ctrl_t;

  typedef struct packed {
    logic crystalMode;
    logic intOscMode;
    logic rcMode;
    logic extClockIn;
    logic clockOutEn;
    logic clockInPinIsIo;
    logic clockOutPinIsIo;
  } dsw_clk_t;
endpackage
`default_nettype wire

//--- dsw_hold_timer.sv
// down-counting reset hold timer, busy while counting
`default_nettype none
module dsw_hold_timer #(
  parameter int COUNT = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  output logic busy
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = CW'(COUNT);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != '0);
endmodule // dsw_hold_timer
`default_nettype wire

//--- dsw_decoder.sv
// device setup word decoder: latches, decodes and applies the setup word
// Notes on behaviour
// RULE1: programmed bit reads 0, unprogrammed 1; fields decoded with that polarity.
// RULE2: setup word sits at 2007h, reachable only while programming.
// RULE3: bits 13-12 trim bandgap; 00 lowest, 11 highest.
// RULE4: bit 8 low enables data memory read-out protection.
// RULE5: processor data EEPROM access unaffected by data protection.
// RULE6: turning data protection off erases the whole data EEPROM first.
// RULE7: bit 7 low enables program memory read-out protection.
// RULE8: turning program protection off erases all program memory, calibration too.
// RULE9: bit 6 high enables brown-out detect; it does not enable power-up timer.
// RULE10: bit 5 high makes shared pin the reset input; low makes it I/O.
// RULE11: external reset in internal or RC modes stops the internal oscillator.
// RULE12: bit 4 low enables the power-up timer.
// RULE13: power-up timer holds reset 72 ms, only after power-up.
// RULE14: bit 3 high enables watchdog, which runs from its own oscillator.
// RULE15: codes 111/110 pick RC with clock output or I/O.
// RULE16: codes 101/100 pick internal oscillator with clock output or I/O.
// RULE17: 011 external clock; 010, 001, 000 the three crystal modes.
// RULE18: in crystal modes start-up timer holds reset until oscillator settles.
// RULE19: brown-out with detect enabled resets device for at least 72 ms.
// RULE20: crystal modes also accept an external clock on the input pin.
// RULE21: sleep ends on external reset, watchdog wake-up or interrupt.
// RULE22: setup controls latched during reset, constant until reprogrammed.
`default_nettype none
module dsw_decoder #(
  parameter int POWERUP_TIMER_COUNT = dsw_pkg::POWERUP_TIMER_CYCLES,
  parameter int OST_COUNT = dsw_pkg::OST_CYCLES_DEFAULT,
  parameter int BOD_COUNT = dsw_pkg::POWERUP_TIMER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  // programmer port, active only in programming mode
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progWrData,
  output logic [13:0] progRdData,
  // non-volatile copy of the word
  input wire logic [13:0] nvSetupWord,
  output logic nvWriteStrobe,
  output logic [13:0] nvWriteData,
  // events from the rest of the device
  input wire logic powerOnEvent,
  input wire logic brownoutEvent,
  input wire logic resetPinIn,
  input wire logic watchdogWake,
  input wire logic interruptWake,
  input wire logic sleepRequest,
  input wire logic dataEraseDone,
  input wire logic progEraseDone,
  // decoded controls
  output dsw_pkg::dsw_ctrl_t setupCtrl,
  output dsw_pkg::dsw_clk_t clkCtrl,
  output logic externalResetActive,
  output logic internalOscStop,
  output logic deviceResetHold,
  output logic dataReadoutBlock,
  output logic progReadoutBlock,
  output logic dataEraseReq,
  output logic progEraseReq,
  output logic watchdogOwnOscEn,
  output logic sleeping
);
  // reset pin, brown-out and interrupt inputs are double flopped
  logic [1:0] pinSync_q;
  logic [1:0] brownSync_q;
  logic [1:0] wakeSync_q;
  logic resetPin, brownout, wakeIrq;
  logic [13:0] word_q, word_d;
  logic dataProt_q, dataProt_d, progProt_q, progProt_d;
  logic dataErase_q, dataErase_d, progErase_q, progErase_d;
  logic sleep_q, sleep_d;
  logic nvStb_q, nvStb_d;
  logic [13:0] nvData_q, nvData_d;
  logic [13:0] rdData_q, rdData_d;
  logic porStart_q, porStart_d;
  logic brownPrev_q, brownPrev_d;
  logic pwrtBusy, ostBusy, bodBusy;
  logic isCrystal, isIntOrRc, progAccess;
  dsw_pkg::dsw_clksel_t clkSel;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinSync_q <= 2'h3;
      brownSync_q <= 2'h0;
      wakeSync_q <= 2'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], resetPinIn};
      brownSync_q <= {brownSync_q[0], brownoutEvent};
      wakeSync_q <= {wakeSync_q[0], interruptWake};
    end
  end
  assign resetPin = pinSync_q[1];
  assign brownout = brownSync_q[1];
  assign wakeIrq = wakeSync_q[1];

  // setup word location check
  assign progAccess = progMode && (progAddr == dsw_pkg::SETUP_WORD_ADDR); // [RULE2]

  // live word: loaded during reset, else only changed by the programmer
  always_comb begin
    word_d = word_q;
    nvStb_d = 1'b0;
    nvData_d = nvData_q;
    rdData_d = rdData_q;
    if (rst) begin
      word_d = nvSetupWord & dsw_pkg::SETUP_IMPL_MASK; // [RULE22]
    end else if (progAccess) begin // [RULE2]
      rdData_d = word_q;
      if (progWrite) begin
        word_d = progWrData & dsw_pkg::SETUP_IMPL_MASK;
        nvStb_d = 1'b1;
        nvData_d = progWrData & dsw_pkg::SETUP_IMPL_MASK;
      end
    end
  end

  // protection state: enabling is immediate; release waits for erase
  always_comb begin
    dataProt_d = dataProt_q;
    progProt_d = progProt_q;
    dataErase_d = dataErase_q;
    progErase_d = progErase_q;
    if (rst) begin
      dataProt_d = ~nvSetupWord[dsw_pkg::DATA_PROT_BIT]; // [RULE4]
      progProt_d = ~nvSetupWord[dsw_pkg::PROG_PROT_BIT]; // [RULE7]
      dataErase_d = 1'b0;
      progErase_d = 1'b0;
    end else begin
      // follow the incoming word so protection moves with the store strobe
      if (!word_d[dsw_pkg::DATA_PROT_BIT] && !dataErase_q) begin
        dataProt_d = 1'b1; // [RULE4]
      end else if (word_d[dsw_pkg::DATA_PROT_BIT] && dataProt_q && !dataErase_q) begin
        dataErase_d = 1'b1; // [RULE6]
      end else if (dataErase_q && dataEraseDone) begin
        dataErase_d = 1'b0;
        dataProt_d = ~word_d[dsw_pkg::DATA_PROT_BIT]; // [RULE6]
      end
      if (!word_d[dsw_pkg::PROG_PROT_BIT] && !progErase_q) begin
        progProt_d = 1'b1; // [RULE7]
      end else if (word_d[dsw_pkg::PROG_PROT_BIT] && progProt_q && !progErase_q) begin
        progErase_d = 1'b1; // [RULE8]
      end else if (progErase_q && progEraseDone) begin
        progErase_d = 1'b0;
        progProt_d = ~word_d[dsw_pkg::PROG_PROT_BIT]; // [RULE8]
      end
    end
  end

  // power-on start pulse and one-cycle delayed brown-out level
  always_comb begin
    porStart_d = powerOnEvent;
    brownPrev_d = brownout;
  end

  // sleep: wake on external reset, watchdog wake-up or interrupt
  // a wake event beats a sleep request in the same cycle, so no wake is lost
  always_comb begin
    sleep_d = sleep_q;
    if (externalResetActive || watchdogWake || wakeIrq) begin // [RULE21]
      sleep_d = 1'b0;
    end else if (sleepRequest) begin
      sleep_d = 1'b1;
    end
  end

  // no reset branch: the word reloads from storage on every clock edge while rst is high
  always_ff @(posedge sys_clk) begin
    word_q <= word_d;
  end

  always_ff @(posedge sys_clk) begin
    dataProt_q <= dataProt_d;
    progProt_q <= progProt_d;
    dataErase_q <= dataErase_d;
    progErase_q <= progErase_d;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nvStb_q <= 1'b0;
      nvData_q <= '0;
      rdData_q <= '0;
    end else begin
      nvStb_q <= nvStb_d;
      nvData_q <= nvData_d;
      rdData_q <= rdData_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      porStart_q <= 1'b0;
      brownPrev_q <= 1'b0;
    end else begin
      porStart_q <= porStart_d;
      brownPrev_q <= brownPrev_d;
    end
  end

  // field decode, programmed bit reads 0
  assign clkSel = dsw_pkg::dsw_clksel_t'(word_q[dsw_pkg::CLKSEL_HI:dsw_pkg::CLKSEL_LO]);
  always_comb begin
    setupCtrl.bandgapTrim = word_q[dsw_pkg::BG_HI:dsw_pkg::BG_LO]; // [RULE3] [RULE1]
    setupCtrl.dataProtect = dataProt_q; // [RULE4]
    setupCtrl.progProtect = progProt_q; // [RULE7]
    setupCtrl.brownoutDetectEn = word_q[dsw_pkg::BROWNOUT_BIT]; // [RULE9]
    setupCtrl.resetPinIsReset = word_q[dsw_pkg::RESET_PIN_BIT]; // [RULE10]
    setupCtrl.powerupTimerEn = ~word_q[dsw_pkg::POWERUP_TIMER_BIT]; // [RULE12] [RULE1]
    setupCtrl.watchdogEn = word_q[dsw_pkg::WATCHDOG_BIT]; // [RULE14]
    setupCtrl.clockSourceSelect = clkSel;
  end

  always_comb begin
    clkCtrl = '0;
    unique case (clkSel)
      dsw_pkg::CLK_RC_CLKOUT: begin
        clkCtrl.rcMode = 1'b1;
        clkCtrl.clockOutEn = 1'b1; // [RULE15]
      end
      dsw_pkg::CLK_RC_IO: begin
        clkCtrl.rcMode = 1'b1;
        clkCtrl.clockOutPinIsIo = 1'b1; // [RULE15]
      end
      dsw_pkg::CLK_INTERNAL_OSCILLATOR_CLKOUT: begin
        clkCtrl.intOscMode = 1'b1;
        clkCtrl.clockOutEn = 1'b1;
        clkCtrl.clockInPinIsIo = 1'b1; // [RULE16]
      end
      dsw_pkg::CLK_INTERNAL_OSCILLATOR_IO: begin
        clkCtrl.intOscMode = 1'b1;
        clkCtrl.clockInPinIsIo = 1'b1;
        clkCtrl.clockOutPinIsIo = 1'b1; // [RULE16]
      end
      dsw_pkg::CLK_EXTERNAL: begin
        clkCtrl.extClockIn = 1'b1;
        clkCtrl.clockOutPinIsIo = 1'b1; // [RULE17]
      end
      dsw_pkg::CLK_HIGH_SPEED_XTAL, dsw_pkg::CLK_STD_XTAL,
      dsw_pkg::CLK_LOW_POWER_XTAL: begin
        clkCtrl.crystalMode = 1'b1; // [RULE17]
        clkCtrl.extClockIn = 1'b1; // [RULE20]
      end
    endcase
  end

  assign isCrystal = clkCtrl.crystalMode;
  assign isIntOrRc = clkCtrl.intOscMode | clkCtrl.rcMode;

  // pin as I/O keeps the external reset inactive
  assign externalResetActive = setupCtrl.resetPinIsReset & ~resetPin; // [RULE10]
  assign internalOscStop = externalResetActive & isIntOrRc; // [RULE11]

  // power-up timer armed only by power-on, never by brown-out alone
  dsw_hold_timer #(.COUNT(POWERUP_TIMER_COUNT)) u_powerup_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(porStart_q & setupCtrl.powerupTimerEn), // [RULE13] [RULE9]
    .busy(pwrtBusy)
  );

  dsw_hold_timer #(.COUNT(OST_COUNT)) u_ost (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(porStart_q & isCrystal), // [RULE18]
    .busy(ostBusy)
  );

  // brown-out reset stretched by its own counter
  dsw_hold_timer #(.COUNT(BOD_COUNT)) u_bod (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(brownout & setupCtrl.brownoutDetectEn), // [RULE19]
    .busy(bodBusy)
  );

  assign deviceResetHold = pwrtBusy | (ostBusy & isCrystal) | bodBusy |
                           externalResetActive | porStart_q |
                           (brownPrev_q & setupCtrl.brownoutDetectEn); // [RULE18] [RULE19]

  // only external read-out is blocked; core access paths are untouched
  assign dataReadoutBlock = dataProt_q; // [RULE5]
  assign progReadoutBlock = progProt_q;
  assign dataEraseReq = dataErase_q; // [RULE6]
  assign progEraseReq = progErase_q; // [RULE8]
  assign watchdogOwnOscEn = setupCtrl.watchdogEn; // [RULE14]
  assign sleeping = sleep_q;
  assign nvWriteStrobe = nvStb_q;
  assign nvWriteData = nvData_q;
  assign progRdData = rdData_q;
endmodule // dsw_decoder
`default_nettype wire

//--- dsw_monitor.sv
// assertion checker for the setup word decoder ports
`default_nettype none
module dsw_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progWrData,
  input wire logic nvWriteStrobe,
  input wire logic [13:0] nvWriteData,
  input wire logic powerOnEvent,
  input wire logic dataEraseDone,
  input wire logic progEraseDone,
  input wire dsw_pkg::dsw_ctrl_t setupCtrl,
  input wire dsw_pkg::dsw_clk_t clkCtrl,
  input wire logic externalResetActive,
  input wire logic internalOscStop,
  input wire logic deviceResetHold,
  input wire logic dataReadoutBlock,
  input wire logic progReadoutBlock,
  input wire logic dataEraseReq,
  input wire logic progEraseReq,
  input wire logic watchdogOwnOscEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic take;
  logic [2:0] cs;
  assign take = progMode && progWrite && progAddr == 14'h2007;
  assign cs = setupCtrl.clockSourceSelect;
  property p_take;
    take |=> nvWriteStrobe && nvWriteData == ($past(progWrData) & 14'h31ff);
  endproperty
  a_take: assert property (p_take) else $error("word not stored");
  property p_refuse;
    !take |=> !nvWriteStrobe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("stray store");
  property p_fields;
    nvWriteStrobe |-> setupCtrl.bandgapTrim == nvWriteData[13:12]
      && setupCtrl.dataProtect == (!nvWriteData[8] || dataEraseReq)
      && setupCtrl.progProtect == (!nvWriteData[7] || progEraseReq);
  endproperty
  a_fields: assert property (p_fields) else $error("trim or protect");
  property p_flags;
    nvWriteStrobe |-> setupCtrl.brownoutDetectEn == nvWriteData[6]
      && setupCtrl.resetPinIsReset == nvWriteData[5] && setupCtrl.powerupTimerEn != nvWriteData[4]
      && watchdogOwnOscEn == nvWriteData[3] && cs == nvWriteData[2:0];
  endproperty
  a_flags: assert property (p_flags) else $error("flag decode");
  property p_clk;
    clkCtrl.crystalMode == (cs <= 3'h2) && clkCtrl.intOscMode == (cs[2:1] == 2'h2)
      && clkCtrl.rcMode == (cs[2:1] == 2'h3) && clkCtrl.clockOutEn == (cs[2] && cs[0])
      && clkCtrl.extClockIn == (cs <= 3'h3);
  endproperty
  a_clk: assert property (p_clk) else $error("clock mode");
  property p_stop;
    internalOscStop == (externalResetActive && (clkCtrl.intOscMode || clkCtrl.rcMode));
  endproperty
  a_stop: assert property (p_stop) else $error("osc stop");
  property p_pinio;
    !setupCtrl.resetPinIsReset |-> !externalResetActive;
  endproperty
  a_pinio: assert property (p_pinio) else $error("pin is io");
  // a reload during reset may change the controls, so the edge after it is excused;
  // protection may drop after an erase, which the two release checks below watch
  property p_keep;
    !nvWriteStrobe && !$past(rst) |-> $stable(setupCtrl & 11'h67f)
      && !$rose(setupCtrl.dataProtect) && !$rose(setupCtrl.progProtect);
  endproperty
  a_keep: assert property (p_keep) else $error("controls moved");
  property p_dataoff;
    $fell(dataReadoutBlock) && !$past(rst) |-> $past(dataEraseDone);
  endproperty
  a_dataoff: assert property (p_dataoff) else $error("data unblocked early");
  property p_progoff;
    $fell(progReadoutBlock) && !$past(rst) |-> $past(progEraseDone);
  endproperty
  a_progoff: assert property (p_progoff) else $error("prog unblocked early");
  property p_por;
    powerOnEvent && setupCtrl.powerupTimerEn |=> deviceResetHold [*8];
  endproperty
  a_por: assert property (p_por) else $error("no power-up hold");
  cover property (take);
  cover property ($fell(progReadoutBlock));
  cover property (internalOscStop);
endmodule // dsw_monitor
bind dsw_decoder dsw_monitor dsw_monitor_inst (
  .sys_clk, .rst, .progMode, .progWrite, .progAddr, .progWrData, .nvWriteStrobe,
  .nvWriteData, .powerOnEvent, .dataEraseDone, .progEraseDone, .setupCtrl, .clkCtrl,
  .externalResetActive, .internalOscStop, .deviceResetHold, .dataReadoutBlock,
  .progReadoutBlock, .dataEraseReq, .progEraseReq, .watchdogOwnOscEn
);
`default_nettype wire

//--- dsw_programmer_model.sv
// programmer model driving the setup word access port
`default_nettype none
module dsw_programmer_model (
  input wire logic sys_clk,
  output logic progMode = 1'b0,
  output logic progWrite = 1'b0,
  output logic [13:0] progAddr = 14'h0,
  output logic [13:0] progWrData = 14'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic put(input logic [13:0] a, input logic [13:0] d, input logic m);
    @(posedge sys_clk);
    progMode <= m;
    progWrite <= 1'b1;
    progAddr <= a;
    progWrData <= d;
    @(posedge sys_clk);
    progMode <= 1'b0;
    progWrite <= 1'b0;
    // released lines must not look like a held word
    progAddr <= ~a;
    progWrData <= ~d;
  endtask
endmodule // dsw_programmer_model
`default_nettype wire

//--- dsw_decoder_test.sv
// self-checking bench for the setup word decoder
`default_nettype none
module dsw_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] nvSetupWord = 14'h31ff;
  logic powerOnEvent = 1'b0;
  logic brownoutEvent = 1'b0;
  logic resetPinIn = 1'b1;
  logic watchdogWake = 1'b0;
  logic interruptWake = 1'b0;
  logic sleepRequest = 1'b0;
  logic dataEraseDone = 1'b0;
  logic progEraseDone = 1'b0;
  logic eraseGo = 1'b0;
  logic progMode, progWrite, nvWriteStrobe;
  logic [13:0] progAddr, progWrData, nvWriteData, e, progRdData;
  logic [10:0] pend;
  dsw_pkg::dsw_ctrl_t setupCtrl;
  dsw_pkg::dsw_clk_t clkCtrl;
  logic externalResetActive, internalOscStop, deviceResetHold, dataReadoutBlock;
  logic progReadoutBlock, dataEraseReq, progEraseReq, watchdogOwnOscEn, sleeping;
  logic [13:0] q [$];
  logic [13:0] hw [5] = '{14'h31a3, 14'h31f3, 14'h31f3, 14'h31b3, 14'h31b1};
  logic [4:0] hb = 5'b01100;
  logic [4:0] hx = 5'b10101;
  integer seed = 14;
  int failures = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  dsw_programmer_model dsw_programmer_model_inst (.sys_clk, .progMode, .progWrite, .progAddr,
    .progWrData);
  dsw_decoder #(.POWERUP_TIMER_COUNT(20), .OST_COUNT(20), .BOD_COUNT(20)) dsw_decoder_inst (
    .sys_clk, .rst, .progMode, .progWrite, .progAddr, .progWrData, .progRdData,
    .nvSetupWord, .nvWriteStrobe, .nvWriteData, .powerOnEvent, .brownoutEvent, .resetPinIn,
    .watchdogWake, .interruptWake, .sleepRequest, .dataEraseDone, .progEraseDone, .setupCtrl,
    .clkCtrl, .externalResetActive, .internalOscStop, .deviceResetHold, .dataReadoutBlock,
    .progReadoutBlock, .dataEraseReq, .progEraseReq, .watchdogOwnOscEn, .sleeping);
  // erase engines answer only once allowed, to show the block waits for them
  always @(posedge sys_clk) begin
    dataEraseDone <= eraseGo && dataEraseReq && !dataEraseDone;
    progEraseDone <= eraseGo && progEraseReq && !progEraseDone;
  end
  function automatic logic [10:0] ctl(input logic [13:0] w);
    return {w[13:12], ~w[8], ~w[7], w[6], w[5], ~w[4], w[3], w[2:0]};
  endfunction
  function automatic logic [6:0] modes(input logic [2:0] c);
    return {c <= 3'h2, c[2:1] == 2'h2, c[2:1] == 2'h3, c <= 3'h3, c == 3'h5 || c == 3'h7,
      c[2:1] == 2'h2, c == 3'h3 || c == 3'h4 || c == 3'h6};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] x, input string m);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [13:0] d, input logic [13:0] a, input logic m);
    if (a == 14'h2007 && m)
      q.push_back(d & 14'h31ff);
    dsw_programmer_model_inst.put(a, d, m);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (nvWriteStrobe === 1'b1) begin
      if (q.size() == 0)
        chk(1'b1, 1'b0, "stray store");
      else begin
        e = q.pop_front();
        // protection stays up while an erase is still pending
        pend = {2'h0, dataEraseReq, progEraseReq, 7'h0};
        chk(nvWriteData, e, "stored word");
        chk(setupCtrl, ctl(e) | pend, "decode");
        chk(clkCtrl, modes(e[2:0]), "clock mode");
      end
    end
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    wrap_up();
  end
  initial begin
    logic [13:0] d;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    nvSetupWord <= 14'h0;
    settle(3);
    chk(setupCtrl, ctl(14'h31ff), "reset load");
    wr(14'h3003, 14'h2007, 1'b1);
    wr(14'h3183, 14'h2007, 1'b1);
    settle(5);
    chk({dataReadoutBlock, progReadoutBlock, dataEraseReq, progEraseReq}, 4'hf, "wait");
    eraseGo <= 1'b1;
    settle(3);
    chk({dataReadoutBlock, progReadoutBlock, dataEraseReq, progEraseReq}, 4'h0, "done");
    for (int i = 0; i < 8; i++) begin
      d = 14'($random(seed));
      wr({d[13:3], i[2:0]}, 14'h2007, 1'b1);
    end
    wr(14'h0, 14'h2006, 1'b1);
    wr(14'h0, 14'h2007, 1'b0);
    settle(2);
    chk(setupCtrl, ctl({d[13:3], 3'h7}), "refused");
    wr(14'h31a4, 14'h2007, 1'b1);
    resetPinIn <= 1'b0;
    settle(4);
    chk({externalResetActive, internalOscStop}, 2'h3, "pin reset");
    chk(progRdData, {d[13:3], 3'h7} & 14'h31ff, "read back");
    resetPinIn <= 1'b1;
    wr(14'h3184, 14'h2007, 1'b1);
    resetPinIn <= 1'b0;
    settle(4);
    chk({externalResetActive, internalOscStop}, 2'h0, "pin io");
    resetPinIn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(hw[i], 14'h2007, 1'b1);
      powerOnEvent <= !hb[i];
      brownoutEvent <= hb[i];
      @(posedge sys_clk);
      powerOnEvent <= 1'b0;
      brownoutEvent <= 1'b0;
      settle(10);
      chk(deviceResetHold, hx[i], "hold");
      settle(40);
      chk(deviceResetHold, 1'b0, "hold end");
    end
    for (int i = 0; i < 3; i++) begin
      sleepRequest <= 1'b1;
      @(posedge sys_clk);
      sleepRequest <= 1'b0;
      settle(3);
      chk(sleeping, 1'b1, "asleep");
      interruptWake <= (i == 0);
      watchdogWake <= (i == 1);
      resetPinIn <= (i != 2);
      @(posedge sys_clk);
      interruptWake <= 1'b0;
      watchdogWake <= 1'b0;
      settle(4);
      chk(sleeping, 1'b0, "woken");
      resetPinIn <= 1'b1;
      settle(4);
    end
    rst <= 1'b1;
    settle(2);
    rst <= 1'b0;
    settle(2);
    chk(setupCtrl, ctl(14'h0), "reload");
    chk(clkCtrl, modes(3'h0), "reload mode");
    chk(q.size(), 0, "unanswered");
    wrap_up();
  end
endmodule // dsw_decoder_test
`default_nettype wire
